// *** verilog/chp_pkg.sv ***
// package: constants and carriers for the compatibility host port
package chp_pkg;
  localparam int CMD_FIFO_DEPTH  = 12;
  localparam int STAT_FIFO_DEPTH = 12;
  localparam int CNT_W           = 4;
  // sub-CPU reset pulse length, 80 ns rounded up to whole cycles
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SUBRST_TIME_NS  = 80;
  localparam int SUBRST_CYCLES   =
    (SUBRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SUBRST_CNT_INIT = 4'(SUBRST_CYCLES);
  // second-mode address decode
  localparam logic [1:0] ADDR_CMD_DATA = 2'h0;
  localparam logic [1:0] ADDR_RST_TST  = 2'h1;
  localparam logic [1:0] ADDR_HCFG     = 2'h2;
  // host configuration fields
  localparam int HCFG_DMA16_BIT   = 0;
  localparam int HCFG_LOHI_BIT    = 1;
  localparam int HCFG_DRQSEL_BIT  = 2;
  localparam int HCFG_SUSPEND_BIT = 3;
  localparam logic [3:0] HCFG_RESET = 4'h0;
  // transfer status fixed top bits
  localparam logic [1:0] XSTAT_TOP = 2'h3;

  typedef enum logic {CHP_MODE_FIRST, CHP_MODE_SECOND} chp_mode_t;

  typedef enum logic [2:0] {
    CHP_OP_NONE, CHP_OP_CMD_WR, CHP_OP_STAT_RD, CHP_OP_DATA_WR,
    CHP_OP_DATA_RD, CHP_OP_SUB_RST, CHP_OP_XSTAT_RD, CHP_OP_HCFG_WR
  } chp_op_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } chp_byte_t;
endpackage

// *** verilog/chp_skid.sv ***
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module chp_skid
  import chp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // filling side
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  // draining side
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready,
  // flush
  input  wire logic       flush
);
  logic [7:0] mem [2];
  logic       wp;
  logic       rp;
  logic [1:0] cnt;

  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = mem[rp];

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (in_valid && in_ready) begin
        mem[wp] <= in_data;
        wp      <= ~wp;
      end
      if (out_valid && out_ready) begin
        rp <= ~rp;
      end
      cnt <= cnt + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end
  end
endmodule

// *** verilog/chp_host_port.sv ***
// compatibility-mode host port: decode, command/status FIFOs, status reg
// Function
// - first mode: select low decodes command/status or data; high ignored
// - twelve-byte command FIFO from host to sub-CPU
// - command write raises sub-CPU interrupt until FIFO emptied
// - command write into full FIFO is discarded
// - with command break set, command write aborts data/status transfer
// - twelve-byte status FIFO from sub-CPU to host
// - status-available pin low while status bytes wait
// - data transfers only while sub-CPU enabled them, shown by data-enable; DMA-selected writes and DMA-ack reads pass without it
// - second mode decodes addresses 00, 01, 10; DMA ack moves DMA data
// - address 00 goes to data only if non-DMA, started, not suspended
// - DMA or non-DMA choice comes from host configuration
// - second-mode FIFOs behave as in first mode
// - reset location write pulses sub-CPU reset low, registers untouched
// - transfer status: 1,1,eject,wait,eop,status,data-enable,request
// - eop, status and data-enable bits follow first-mode pins
// - wait bit mirrors wait pin when non-DMA, else reads 1
// - request bit mirrors wait pin when DMA, else reads 0
// - DMA only when request-select bit low and select pin low
// - suspend bit stops non-DMA data, no effect on DMA
// - device reset clears host configuration
`timescale 1ns/1ps
module chp_host_port
  import chp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // mode and pins
  input  wire logic       mode_second,
  input  wire logic       host_select_n,
  input  wire logic       host_read_strobe_n,
  input  wire logic       host_write_strobe_n,
  input  wire logic       command_sel,
  input  wire logic       host_addr_1,
  input  wire logic       host_addr_0,
  input  wire logic       dma_acknowledge_n,
  input  wire logic       dma_select_pin,
  input  wire logic       eject_pin,
  input  wire logic [7:0] host_data_in,
  output logic [7:0]      host_data_out,
  output logic            host_data_oe,
  output logic            status_available_n,
  output logic            data_enable_n,
  output logic            subcpu_reset_n,
  // sub-CPU side
  input  wire logic       command_break,
  input  wire logic       cmd_pop,
  output logic [7:0]      cmd_head,
  output logic            cmd_nonempty,
  output logic            command_present_irq,
  input  wire logic       stat_push,
  input  wire logic [7:0] stat_byte,
  output logic            stat_full,
  input  wire logic       xfer_start,
  input  wire logic       xfer_stop,
  input  wire logic       end_of_process_in,
  input  wire logic       wait_in,
  output logic            xfer_abort,
  output logic            end_of_process,
  output logic            wait_pin,
  output logic [3:0]      host_configuration_out,
  output logic            dma_mode,
  // data path to memory engine
  output chp_byte_t       wr_data,
  input  wire logic       wr_ready,
  input  wire chp_byte_t  rd_data,
  output logic            rd_taken
);
  logic [7:0] cmd_mem  [CMD_FIFO_DEPTH];
  logic [7:0] stat_mem [STAT_FIFO_DEPTH];
  logic [CNT_W-1:0] cmd_wp, cmd_rp, stat_wp, stat_rp;
  logic [CNT_W:0]   cmd_cnt, stat_cnt;
  logic [3:0]       host_configuration;
  logic [3:0]       rst_cnt;
  logic             xfer_on;
  logic             rd_prev, wr_prev;
  logic             rd_edge, wr_edge;
  logic             data_sel, dma_sel;
  chp_op_t          op;
  logic             cmd_full, stat_empty;
  logic             skid_in_ready, skid_out_valid;
  logic [7:0]       skid_out_data;
  logic [7:0]       xfer_stat;

  // strobe falling edges, so a held strobe acts once
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_prev <= 1'b1;
      wr_prev <= 1'b1;
    end else begin
      rd_prev <= host_read_strobe_n;
      wr_prev <= host_write_strobe_n;
    end
  end
  assign rd_edge = rd_prev && !host_read_strobe_n && host_write_strobe_n;
  assign wr_edge = wr_prev && !host_write_strobe_n && host_read_strobe_n;

  // transfer selection
  assign dma_sel = mode_second &&
                   !host_configuration[HCFG_DRQSEL_BIT] &&
                   !dma_select_pin;
  assign data_sel = !dma_sel && xfer_on &&
                    !(mode_second &&
                      host_configuration[HCFG_SUSPEND_BIT]);

  // operation decode
  always_comb begin
    op = CHP_OP_NONE;
    if (!mode_second) begin
      if (!host_select_n) begin
        if (wr_edge) begin
          op = command_sel ? CHP_OP_DATA_WR : CHP_OP_CMD_WR;
        end else if (rd_edge) begin
          op = command_sel ? CHP_OP_DATA_RD : CHP_OP_STAT_RD;
        end
      end
    end else if (!dma_acknowledge_n) begin
      if (wr_edge) begin
        op = CHP_OP_DATA_WR;
      end else if (rd_edge) begin
        op = CHP_OP_DATA_RD;
      end
    end else if (!host_select_n) begin
      case ({host_addr_1, host_addr_0})
        ADDR_CMD_DATA: begin
          if (wr_edge) begin
            op = data_sel ? CHP_OP_DATA_WR : CHP_OP_CMD_WR;
          end else if (rd_edge) begin
            op = data_sel ? CHP_OP_DATA_RD : CHP_OP_STAT_RD;
          end
        end
        ADDR_RST_TST: begin
          if (wr_edge) begin
            op = CHP_OP_SUB_RST;
          end else if (rd_edge) begin
            op = CHP_OP_XSTAT_RD;
          end
        end
        ADDR_HCFG: begin
          if (wr_edge) begin
            op = CHP_OP_HCFG_WR;
          end
        end
        default: op = CHP_OP_NONE;
      endcase
    end
  end

  // command FIFO
  assign cmd_full = (cmd_cnt == (CNT_W+1)'(CMD_FIFO_DEPTH));
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_wp  <= '0;
      cmd_rp  <= '0;
      cmd_cnt <= '0;
    end else begin
      // full FIFO drops the byte, contents kept
      if (op == CHP_OP_CMD_WR && !cmd_full) begin
        cmd_mem[cmd_wp] <= host_data_in;
        cmd_wp <= (cmd_wp == CNT_W'(CMD_FIFO_DEPTH-1)) ? '0 : cmd_wp + 1'b1;
      end
      if (cmd_pop && cmd_cnt != '0) begin
        cmd_rp <= (cmd_rp == CNT_W'(CMD_FIFO_DEPTH-1)) ? '0 : cmd_rp + 1'b1;
      end
      cmd_cnt <= cmd_cnt + (CNT_W+1)'(op == CHP_OP_CMD_WR && !cmd_full)
                         - (CNT_W+1)'(cmd_pop && cmd_cnt != '0);
    end
  end
  assign cmd_head     = cmd_mem[cmd_rp];
  assign cmd_nonempty = (cmd_cnt != '0);

  // interrupt: set wins over the emptying pop
  always_ff @(posedge clk) begin
    if (rst) begin
      command_present_irq <= 1'b0;
    end else if (op == CHP_OP_CMD_WR) begin
      command_present_irq <= 1'b1;
    end else if (cmd_cnt == '0) begin
      command_present_irq <= 1'b0;
    end
  end

  // status FIFO
  assign stat_empty = (stat_cnt == '0);
  assign stat_full  = (stat_cnt == (CNT_W+1)'(STAT_FIFO_DEPTH));
  always_ff @(posedge clk) begin
    if (rst || xfer_abort) begin
      stat_wp  <= '0;
      stat_rp  <= '0;
      stat_cnt <= '0;
    end else begin
      if (stat_push && !stat_full) begin
        stat_mem[stat_wp] <= stat_byte;
        stat_wp <= (stat_wp == CNT_W'(STAT_FIFO_DEPTH-1)) ? '0
                 : stat_wp + 1'b1;
      end
      if (op == CHP_OP_STAT_RD && !stat_empty) begin
        stat_rp <= (stat_rp == CNT_W'(STAT_FIFO_DEPTH-1)) ? '0
                 : stat_rp + 1'b1;
      end
      stat_cnt <= stat_cnt + (CNT_W+1)'(stat_push && !stat_full)
                - (CNT_W+1)'(op == CHP_OP_STAT_RD && !stat_empty);
    end
  end

  // break: command write aborts data and status transfer
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_abort <= 1'b0;
    end else begin
      xfer_abort <= (op == CHP_OP_CMD_WR) && command_break;
    end
  end

  // transfer enable from sub-CPU; start wins over stop
  always_ff @(posedge clk) begin
    if (rst) begin
      xfer_on <= 1'b0;
    end else if (xfer_start) begin
      xfer_on <= 1'b1;
    end else if (xfer_stop || xfer_abort) begin
      xfer_on <= 1'b0;
    end
  end

  // pins, all registered
  always_ff @(posedge clk) begin
    if (rst) begin
      status_available_n <= 1'b1;
      data_enable_n      <= 1'b1;
      end_of_process     <= 1'b0;
      wait_pin           <= 1'b1;
      dma_mode           <= 1'b0;
    end else begin
      status_available_n <= stat_empty;
      data_enable_n      <= !xfer_on;
      end_of_process     <= end_of_process_in;
      wait_pin           <= wait_in;
      dma_mode           <= dma_sel;
    end
  end

  // host configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      host_configuration <= HCFG_RESET;
    end else if (op == CHP_OP_HCFG_WR) begin
      host_configuration <= host_data_in[3:0];
    end
  end
  assign host_configuration_out = host_configuration;

  // sub-CPU reset pulse, touches no register
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_cnt        <= '0;
      subcpu_reset_n <= 1'b1;
    end else if (op == CHP_OP_SUB_RST) begin
      rst_cnt        <= SUBRST_CNT_INIT;
      subcpu_reset_n <= 1'b0;
    end else if (rst_cnt != '0) begin
      rst_cnt        <= rst_cnt - 1'b1;
      subcpu_reset_n <= (rst_cnt == 4'h1);
    end
  end

  // transfer status from registered pins, eject pin taken directly
  assign xfer_stat = {XSTAT_TOP, eject_pin,
                      dma_mode ? 1'b1 : wait_pin,
                      end_of_process, status_available_n,
                      data_enable_n,
                      dma_mode ? wait_pin : 1'b0};

  // host read data
  always_ff @(posedge clk) begin
    if (rst) begin
      host_data_out <= 8'h00;
      host_data_oe  <= 1'b0;
    end else begin
      host_data_oe <= !host_read_strobe_n &&
                      (!host_select_n || (mode_second && !dma_acknowledge_n));
      case (op)
        CHP_OP_STAT_RD:  host_data_out <= stat_empty ? 8'h00
                                        : stat_mem[stat_rp];
        CHP_OP_XSTAT_RD: host_data_out <= xfer_stat;
        CHP_OP_DATA_RD:  host_data_out <= rd_data.data;
        default:         host_data_out <= host_data_out;
      endcase
    end
  end
  assign rd_taken = (op == CHP_OP_DATA_RD) && rd_data.valid &&
                    (xfer_on || !dma_acknowledge_n);

  // host data writes buffered toward memory engine
  chp_skid u_wr_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (op == CHP_OP_DATA_WR && (xfer_on || dma_sel)),
    .in_data   (host_data_in),
    .in_ready  (skid_in_ready),
    .out_valid (skid_out_valid),
    .out_data  (skid_out_data),
    .out_ready (wr_ready),
    .flush     (xfer_abort)
  );
  assign wr_data = '{valid: skid_out_valid, data: skid_out_data};

  // assertions
  a_full_write_dropped: assert property (@(posedge clk) disable iff (rst)
    (op == CHP_OP_CMD_WR && cmd_full && !cmd_pop) |=> $stable(cmd_cnt))
    else $error("command write into full FIFO changed count");
  a_irq_on_write: assert property (@(posedge clk) disable iff (rst)
    (op == CHP_OP_CMD_WR) |=> command_present_irq)
    else $error("command write did not raise interrupt");
  a_irq_until_empty: assert property (@(posedge clk) disable iff (rst)
    (command_present_irq && cmd_cnt != '0) |=> command_present_irq)
    else $error("interrupt dropped while FIFO held bytes");
  a_break_aborts: assert property (@(posedge clk) disable iff (rst)
    (op == CHP_OP_CMD_WR && command_break) |=> xfer_abort ##1 !xfer_on)
    else $error("command break did not abort transfer");
  a_status_pin: assert property (@(posedge clk) disable iff (rst)
    (stat_cnt != '0) |=> !status_available_n)
    else $error("status pin high with bytes waiting");
  a_reset_pulse_len: assert property (@(posedge clk) disable iff (rst)
    (op == CHP_OP_SUB_RST) |=> (!subcpu_reset_n) [*8])
    else $error("sub-CPU reset pulse too short");
  a_hcfg_write: assert property (@(posedge clk) disable iff (rst)
    (op == CHP_OP_HCFG_WR) |=> host_configuration == $past(host_data_in[3:0]))
    else $error("host configuration not written");
  a_drq_non_dma: assert property (@(posedge clk) disable iff (rst)
    !dma_mode |-> (xfer_stat[0] == 1'b0 && xfer_stat[4] == wait_pin))
    else $error("transfer status wait or request wrong");
  a_xstat_top: assert property (@(posedge clk) disable iff (rst)
    xfer_stat[7:6] == 2'b11 && xfer_stat[2] == status_available_n)
    else $error("transfer status fixed bits wrong");
  a_dma_select: assert property (@(posedge clk) disable iff (rst)
    (dma_sel) |-> (!host_configuration[HCFG_DRQSEL_BIT] && !dma_select_pin))
    else $error("DMA selected against configuration");
endmodule

// *** tb/chp_host_model.sv ***
// host bus controller model: strobes, selects, address and write data
`timescale 1ns/1ps
module chp_host_model (
  // clock
  input  wire logic       clk,
  // host bus
  output logic            host_select_n,
  output logic            host_read_strobe_n,
  output logic            host_write_strobe_n,
  output logic            command_sel,
  output logic            host_addr_1,
  output logic            host_addr_0,
  output logic            dma_acknowledge_n,
  output logic [7:0]      host_data_in,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe
);
  // extra cycles the strobe is held, to act as a slow host
  int slow;

  initial begin
    {host_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
    {command_sel, host_addr_1, host_addr_0, dma_acknowledge_n} = 4'h1;
    host_data_in = 8'h5A;
  end

  // one access; qualifiers held with the strobe, then a strobe-high gap
  task automatic access(input logic w, input logic sel_n, input logic cs,
                        input logic [1:0] a, input logic ack_n,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    host_select_n = sel_n;
    command_sel = cs;
    {host_addr_1, host_addr_0} = a;
    dma_acknowledge_n = ack_n;
    host_data_in = d;
    host_write_strobe_n = ~w;
    host_read_strobe_n = w;
    repeat (2 + slow) @(negedge clk);
    q = (host_data_oe === 1'b1) ? host_data_out : 8'hXX;
    {host_select_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
    dma_acknowledge_n = 1'b1;
    // released bus never keeps showing the last byte
    host_data_in = ~d;
    @(negedge clk);
  endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the compatibility host port
`timescale 1ns/1ps
module testbench
  import chp_pkg::*;
;
  logic       clk, rst, mode_second, dma_select_pin, eject_pin, wr_ready;
  logic       command_break, cmd_pop, stat_push, xfer_start, xfer_stop;
  logic       end_of_process_in, wait_in, host_data_oe, rd_taken;
  logic       host_select_n, host_read_strobe_n, host_write_strobe_n;
  logic       command_sel, host_addr_1, host_addr_0, dma_acknowledge_n;
  logic       status_available_n, data_enable_n, subcpu_reset_n, dma_mode;
  logic       cmd_nonempty, command_present_irq, stat_full, xfer_abort;
  logic       end_of_process, wait_pin;
  logic [7:0] stat_byte, rd, host_data_in, host_data_out, cmd_head;
  logic [3:0] host_configuration_out;
  chp_byte_t  rd_data, wr_data;
  int         miscompares, checked, cycles, aborts, rst_low, i, takes;
  logic [7:0] wq[$];

  chp_host_port dut (
    .clk, .rst, .mode_second, .host_select_n, .host_read_strobe_n,
    .host_write_strobe_n, .command_sel, .host_addr_1, .host_addr_0,
    .dma_acknowledge_n, .dma_select_pin, .eject_pin, .host_data_in,
    .host_data_out, .host_data_oe, .status_available_n, .data_enable_n,
    .subcpu_reset_n, .command_break, .cmd_pop, .cmd_head, .cmd_nonempty,
    .command_present_irq, .stat_push, .stat_byte, .stat_full, .xfer_start,
    .xfer_stop, .end_of_process_in, .wait_in, .xfer_abort, .end_of_process,
    .wait_pin, .host_configuration_out, .dma_mode, .wr_data, .wr_ready,
    .rd_data, .rd_taken);

  chp_host_model host (
    .clk, .host_select_n, .host_read_strobe_n, .host_write_strobe_n,
    .command_sel, .host_addr_1, .host_addr_0, .dma_acknowledge_n,
    .host_data_in, .host_data_out, .host_data_oe);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchers: engine-side bytes, abort pulses, reset pulse length, hang
  always @(posedge clk) begin
    cycles++;
    if (wr_data.valid === 1'b1 && wr_ready) wq.push_back(wr_data.data);
    if (xfer_abort === 1'b1) aborts++;
    if (rd_taken === 1'b1) takes++;
    if (subcpu_reset_n === 1'b0) rst_low++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic m1(input logic w, input logic cs, input logic [7:0] d);
    host.access(w, 1'b0, cs, 2'h0, 1'b1, d, rd);
  endtask

  task automatic m2(input logic w, input logic [1:0] a, input logic [7:0] d);
    host.access(w, 1'b0, 1'b0, a, 1'b1, d, rd);
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // sub-CPU pulses: pop, push, start, stop
  task automatic sub(input logic [3:0] which, input logic [7:0] d);
    @(negedge clk);
    {cmd_pop, stat_push, xfer_start, xfer_stop} = which;
    stat_byte = d;
    @(negedge clk);
    {cmd_pop, stat_push, xfer_start, xfer_stop} = 4'h0;
  endtask

  initial begin
    {rst, dma_select_pin, eject_pin, wr_ready} = 4'hF;
    {mode_second, command_break, cmd_pop, stat_push} = 4'h0;
    {xfer_start, xfer_stop, wait_in} = 3'h0;
    end_of_process_in = 1'b1;
    stat_byte = 8'h00;
    rd_data = '{valid: 1'b1, data: 8'h77};
    tick(6);
    rst = 1'b0;
    tick(1);
    check(status_available_n, 8'h01);
    check(data_enable_n, 8'h01);
    check(subcpu_reset_n, 8'h01);
    check(host_configuration_out, 8'h00);
    $display("test reset done at %0t", $time);
    host.access(1'b1, 1'b1, 1'b0, 2'h0, 1'b1, 8'h99, rd);
    tick(2);
    check(cmd_nonempty, 8'h00);
    for (i = 0; i < 13; i++) m1(1'b1, 1'b0, 8'h10 + 8'(i));
    check(command_present_irq, 8'h01);
    for (i = 0; i < 12; i++) begin
      check(cmd_head, 8'h10 + 8'(i));
      if (i == 11) check(command_present_irq, 8'h01);
      sub(4'h8, 8'h00);
    end
    tick(2);
    check(cmd_nonempty, 8'h00);
    check(command_present_irq, 8'h00);
    for (i = 0; i < 12; i++) sub(4'h4, 8'hA0 + 8'(i));
    tick(2);
    check(stat_full, 8'h01);
    check(status_available_n, 8'h00);
    // host reads while status is flagged available, then once more after it clears
    for (i = 0; i < 12; i++) begin
      m1(1'b0, 1'b0, 8'h00);
      check(rd, 8'hA0 + 8'(i));
    end
    tick(1);
    check(status_available_n, 8'h01);
    m1(1'b0, 1'b0, 8'h00);
    check(rd, 8'h00);
    $display("test fifos done at %0t", $time);
    // written before any enable: must not reach the engine
    m1(1'b1, 1'b1, 8'h33);
    sub(4'h2, 8'h00);
    tick(2);
    check(data_enable_n, 8'h00);
    wr_ready = 1'b0;
    m1(1'b1, 1'b1, 8'h41);
    m1(1'b1, 1'b1, 8'h42);
    check(8'(wq.size()), 8'h00);
    wr_ready = 1'b1;
    tick(4);
    check(8'(wq.size()), 8'h02);
    check(wq[0], 8'h41);
    check(wq[1], 8'h42);
    m1(1'b0, 1'b1, 8'h00);
    check(rd, 8'h77);
    check(8'(takes), 8'h01);
    sub(4'h1, 8'h00);
    tick(2);
    check(data_enable_n, 8'h01);
    sub(4'h2, 8'h00);
    command_break = 1'b1;
    m1(1'b1, 1'b0, 8'h55);
    tick(2);
    check(8'(aborts), 8'h01);
    check(data_enable_n, 8'h01);
    command_break = 1'b0;
    sub(4'h8, 8'h00);
    $display("test data done at %0t", $time);
    mode_second = 1'b1;
    host.slow = 2;
    m2(1'b1, 2'h2, 8'hF8);
    check(host_configuration_out, 8'h08);
    check(dma_mode, 8'h00);
    sub(4'h2, 8'h00);
    tick(2);
    m2(1'b0, 2'h1, 8'h00);
    check(rd, 8'hEC);
    m2(1'b1, 2'h0, 8'h61);
    check(cmd_head, 8'h61);
    sub(4'h8, 8'h00);
    m2(1'b1, 2'h2, 8'h00);
    m2(1'b1, 2'h0, 8'h62);
    tick(3);
    check(wq[2], 8'h62);
    {dma_select_pin, wait_in, eject_pin} = 3'h2;
    m2(1'b1, 2'h2, 8'h08);
    check(dma_mode, 8'h01);
    m2(1'b0, 2'h1, 8'h00);
    check(rd, 8'hDD);
    host.access(1'b1, 1'b1, 1'b0, 2'h3, 1'b0, 8'h63, rd);
    tick(3);
    check(wq[3], 8'h63);
    m2(1'b1, 2'h0, 8'h64);
    check(cmd_head, 8'h64);
    rst_low = 0;
    m2(1'b1, 2'h1, 8'h00);
    tick(10);
    check(8'(rst_low), 8'(SUBRST_CYCLES));
    check(host_configuration_out, 8'h08);
    check(cmd_head, 8'h64);
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
    check(host_configuration_out, 8'h00);
    $display("test second mode done at %0t", $time);
    end_of_test();
  end
endmodule
